/* inc/obcd_consts.vh */
// constants for the option byte configuration decoder
// assumes inclusion by bare name from the store and core design files of the block
// Notes on behaviour
// - decode three-bit oscillator range field while rc oscillator off
// - sector zero size from two-bit field
// - readout lock outside user and iap
// - locked option erase wipes memory first
// - write lock blocks program flash forever
// - option bytes reachable only in programming
// - top bit picks pll times four/eight
// - bit six bypasses main pll
// - bit five bypasses timer pll
// - bit four switches rc oscillator off
// - detector off or one of three thresholds
// - watchdog bit picks hardware or software
// - halt entry resets when bit set and watchdog active
// - blank device holds all ones content
`ifndef OBCD_CONSTS_VH
`define OBCD_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define OBCD_ADDR_BYTE0 4'h0
`define OBCD_ADDR_BYTE1 4'h1
`define OBCD_ADDR_STATUS 4'h2
`define OBCD_ADDR_CMD 4'h3
`define OBCD_ADDR_LIVE0 4'h4
`define OBCD_ADDR_LIVE1 4'h5

// ****************************************
// field positions
// ****************************************
`define OBCD_B0_RESERVED 7
`define OBCD_B0_OSC_HI 6
`define OBCD_B0_OSC_LO 4
`define OBCD_B0_SEC_HI 3
`define OBCD_B0_SEC_LO 2
`define OBCD_B0_READOUT 1
`define OBCD_B0_WLOCK 0
`define OBCD_B1_PLL_FACTOR 7
`define OBCD_B1_MAIN_BYPASS 6
`define OBCD_B1_TIMER_BYPASS 5
`define OBCD_B1_RC_OFF 4
`define OBCD_B1_LVD_HI 3
`define OBCD_B1_LVD_LO 2
`define OBCD_B1_WATCHDOG_SW_MODE 1
`define OBCD_B1_WATCHDOG_HALT_RESET 0
`define OBCD_CMD_ERASE 0
`define OBCD_CMD_CLR_ERR 1
`define OBCD_ST_PROG 0
`define OBCD_ST_BUSY 1
`define OBCD_ST_ERR 2
`define OBCD_ST_MASS 3

// ****************************************
// values
// ****************************************
`define OBCD_BLANK_BYTE 8'hff
`define OBCD_OSC_1_2MHZ 3'h0
`define OBCD_OSC_2_4MHZ 3'h1
`define OBCD_OSC_4_8MHZ 3'h2
`define OBCD_OSC_8_16MHZ 3'h3
`define OBCD_OSC_32KHZ 3'h4
`define OBCD_OSC_EXT_OSC1 3'h5
`define OBCD_OSC_RESERVED 3'h6
`define OBCD_OSC_EXT_ALT 3'h7
`define OBCD_LVD_OFF 2'h3
`define OBCD_SEC_BASE 13'h0200
`define OBCD_RST_OSC_SEL 3'h7
`define OBCD_RST_SEC_SEL 2'h3
`define OBCD_RST_SEC_BYTES 13'h1000
`define OBCD_RST_LVD_LEVEL 2'h3

`endif

/* rtl/obcd_sync.v */
// two flip-flop synchroniser for one level
// assumes an asynchronous pin level and one core clock
`timescale 1ns/1ps
`default_nettype none
module obcd_sync (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire async_in,
  output wire sync_out
);

  reg meta;
  reg stable;

  // ****************************************
  // two stages, first read only by second
  // ****************************************
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
    end
  end

  assign sync_out = stable;

endmodule // obcd_sync
`default_nettype wire

/* rtl/obcd_nv_store.v */
// non-volatile store of the two option bytes
// assumes power-on reset only at first power, not at device reset
`timescale 1ns/1ps
`default_nettype none
`include "obcd_consts.vh"
module obcd_nv_store (
  input wire core_clk_in,
  input wire por_n_in,
  input wire wr_in,
  input wire wr_sel_in,
  input wire [7:0] wr_data_in,
  input wire wipe_in,
  output reg [7:0] byte0_out,
  output reg [7:0] byte1_out
);

  // ****************************************
  // storage cells
  // ****************************************
  always @(posedge core_clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      byte0_out <= `OBCD_BLANK_BYTE;
      byte1_out <= `OBCD_BLANK_BYTE;
    end else if (wipe_in) begin
      byte0_out <= `OBCD_BLANK_BYTE;
      byte1_out <= `OBCD_BLANK_BYTE;
    end else if (wr_in) begin
      if (wr_sel_in) begin
        byte1_out <= wr_data_in;
      end else begin
        byte0_out <= wr_data_in;
      end
    end
  end

endmodule // obcd_nv_store
`default_nettype wire

/* rtl/obcd_core.v */
// option byte holder and decoder with programming access port
// assumes programming mode arrives on a pin, mode flags on core clock
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "obcd_consts.vh"
module obcd_core (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire por_n_in,
  input wire prog_mode_in,
  input wire user_mode_in,
  input wire in_application_programming_in,
  input wire mass_erase_done_in,
  input wire watchdog_active_in,
  input wire halt_entry_in,
  input wire [3:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  output reg mass_erase_req_out,
  output reg [2:0] osc_range_sel_out,
  output reg range_1_2mhz_out,
  output reg range_2_4mhz_out,
  output reg range_4_8mhz_out,
  output reg range_8_16mhz_out,
  output reg range_32khz_out,
  output reg external_clock_input_osc1_out,
  output reg external_clock_input_alt_out,
  output reg osc_range_reserved_out,
  output reg [1:0] sector0_size_sel_out,
  output reg [12:0] sector0_bytes_out,
  output reg readout_protect_out,
  output reg mem_access_allow_out,
  output reg flash_write_lock_out,
  output reg pll_factor_sel_out,
  output reg main_pll_bypass_out,
  output reg timer_pll_bypass_out,
  output reg rc_osc_on_out,
  output reg low_voltage_detector_en_out,
  output reg [1:0] low_voltage_detector_level_out,
  output reg watchdog_sw_mode_out,
  output reg watchdog_hw_enable_out,
  output reg watchdog_halt_reset_out,
  output reg halt_reset_req_out
);

  // ****************************************
  // functions
  // ****************************************
  function [12:0] sector_bytes;
    input [1:0] sel;
    begin
      sector_bytes = `OBCD_SEC_BASE << sel;
    end
  endfunction

  function osc_is;
    input [2:0] field;
    input [2:0] code;
    input rc_off;
    begin
      osc_is = rc_off && (field == code);
    end
  endfunction

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_MASS = 2'h1;
  localparam [1:0] ST_WIPE = 2'h2;

  wire prog_mode;
  wire [7:0] nv_byte0;
  wire [7:0] nv_byte1;
  reg [7:0] live0;
  reg [7:0] live1;
  reg load_pending;
  reg [1:0] state;
  reg [1:0] next_state;
  reg erase_err;
  reg next_erase_err;
  reg nv_wr;
  reg [7:0] nv_wr_data;
  reg nv_wipe;
  reg [7:0] next_rd_data;
  reg next_mass_req;
  wire rc_off;
  wire [2:0] osc_field;
  wire busy;
  wire cmd_wr;
  wire erase_cmd;

  // ****************************************
  // programming mode pin
  // ****************************************
  obcd_sync u_prog_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(prog_mode_in),
    .sync_out(prog_mode)
  );

  // ****************************************
  // option byte store
  // ****************************************
  obcd_nv_store u_store (
    .core_clk_in(core_clk_in),
    .por_n_in(por_n_in),
    .wr_in(nv_wr),
    .wr_sel_in(addr_in[0]),
    .wr_data_in(nv_wr_data),
    .wipe_in(nv_wipe),
    .byte0_out(nv_byte0),
    .byte1_out(nv_byte1)
  );

  // ****************************************
  // latch at reset release
  // ****************************************
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      live0 <= `OBCD_BLANK_BYTE;
      live1 <= `OBCD_BLANK_BYTE;
      load_pending <= 1'b1;
    end else if (load_pending) begin
      live0 <= nv_byte0;
      live1 <= nv_byte1;
      load_pending <= 1'b0;
    end
  end

  // ****************************************
  // programming access
  // ****************************************
  assign busy = (state != ST_IDLE);
  assign cmd_wr = wr_in && prog_mode && (addr_in == `OBCD_ADDR_CMD);
  assign erase_cmd = cmd_wr && wr_data_in[`OBCD_CMD_ERASE] && !busy;

  always @* begin
    nv_wr = 1'b0;
    nv_wr_data = wr_data_in;
    if (wr_in && prog_mode && !busy) begin
      if (addr_in == `OBCD_ADDR_BYTE0) begin
        nv_wr = 1'b1;
        if (live0[`OBCD_B0_WLOCK]) begin
          nv_wr_data[`OBCD_B0_WLOCK] = 1'b1;
        end
      end else if (addr_in == `OBCD_ADDR_BYTE1) begin
        nv_wr = 1'b1;
      end
    end
  end

  // ****************************************
  // erase sequencer
  // ****************************************
  always @* begin
    next_state = state;
    next_erase_err = erase_err;
    next_mass_req = 1'b0;
    nv_wipe = 1'b0;
    if (cmd_wr && wr_data_in[`OBCD_CMD_CLR_ERR]) begin
      next_erase_err = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (erase_cmd) begin
          if (live0[`OBCD_B0_WLOCK]) begin
            next_erase_err = 1'b1;
          end else if (live0[`OBCD_B0_READOUT]) begin
            next_state = ST_MASS;
            next_mass_req = 1'b1;
          end else begin
            next_state = ST_WIPE;
          end
        end
      end
      ST_MASS: begin
        if (mass_erase_done_in) begin
          next_state = ST_WIPE;
        end else begin
          next_mass_req = 1'b1;
        end
      end
      ST_WIPE: begin
        nv_wipe = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      erase_err <= 1'b0;
      mass_erase_req_out <= 1'b0;
    end else begin
      state <= next_state;
      erase_err <= next_erase_err;
      mass_erase_req_out <= next_mass_req;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @* begin
    next_rd_data = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `OBCD_ADDR_BYTE0: next_rd_data = prog_mode ? nv_byte0 : 8'h00;
        `OBCD_ADDR_BYTE1: next_rd_data = prog_mode ? nv_byte1 : 8'h00;
        `OBCD_ADDR_LIVE0: next_rd_data = prog_mode ? live0 : 8'h00;
        `OBCD_ADDR_LIVE1: next_rd_data = prog_mode ? live1 : 8'h00;
        `OBCD_ADDR_STATUS: begin
          next_rd_data[`OBCD_ST_PROG] = prog_mode;
          next_rd_data[`OBCD_ST_BUSY] = busy;
          next_rd_data[`OBCD_ST_ERR] = erase_err;
          next_rd_data[`OBCD_ST_MASS] = mass_erase_req_out;
        end
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= next_rd_data;
    end
  end

  // ****************************************
  // decoded settings
  // ****************************************
  assign rc_off = live1[`OBCD_B1_RC_OFF];
  // flags decode the latched field so all settings move together
  assign osc_field = live0[`OBCD_B0_OSC_HI:`OBCD_B0_OSC_LO];

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_range_sel_out <= `OBCD_RST_OSC_SEL;
      range_1_2mhz_out <= 1'b0;
      range_2_4mhz_out <= 1'b0;
      range_4_8mhz_out <= 1'b0;
      range_8_16mhz_out <= 1'b0;
      range_32khz_out <= 1'b0;
      external_clock_input_osc1_out <= 1'b0;
      external_clock_input_alt_out <= 1'b0;
      osc_range_reserved_out <= 1'b0;
      sector0_size_sel_out <= `OBCD_RST_SEC_SEL;
      sector0_bytes_out <= `OBCD_RST_SEC_BYTES;
      readout_protect_out <= 1'b1;
      mem_access_allow_out <= 1'b0;
      flash_write_lock_out <= 1'b1;
      pll_factor_sel_out <= 1'b0;
      main_pll_bypass_out <= 1'b1;
      timer_pll_bypass_out <= 1'b1;
      rc_osc_on_out <= 1'b0;
      low_voltage_detector_en_out <= 1'b0;
      low_voltage_detector_level_out <= `OBCD_RST_LVD_LEVEL;
      watchdog_sw_mode_out <= 1'b1;
      watchdog_hw_enable_out <= 1'b0;
      watchdog_halt_reset_out <= 1'b1;
      halt_reset_req_out <= 1'b0;
    end else begin
      osc_range_sel_out <= osc_field;
      range_1_2mhz_out <= osc_is(osc_field, `OBCD_OSC_1_2MHZ, rc_off);
      range_2_4mhz_out <= osc_is(osc_field, `OBCD_OSC_2_4MHZ, rc_off);
      range_4_8mhz_out <= osc_is(osc_field, `OBCD_OSC_4_8MHZ, rc_off);
      range_8_16mhz_out <= osc_is(osc_field, `OBCD_OSC_8_16MHZ, rc_off);
      range_32khz_out <= osc_is(osc_field, `OBCD_OSC_32KHZ, rc_off);
      external_clock_input_osc1_out <= osc_is(osc_field, `OBCD_OSC_EXT_OSC1, rc_off);
      external_clock_input_alt_out <= osc_is(osc_field, `OBCD_OSC_EXT_ALT, rc_off);
      osc_range_reserved_out <= osc_is(osc_field, `OBCD_OSC_RESERVED, rc_off);
      sector0_size_sel_out <= live0[`OBCD_B0_SEC_HI:`OBCD_B0_SEC_LO];
      sector0_bytes_out <= sector_bytes(live0[`OBCD_B0_SEC_HI:`OBCD_B0_SEC_LO]);
      readout_protect_out <= live0[`OBCD_B0_READOUT];
      mem_access_allow_out <= !live0[`OBCD_B0_READOUT] || user_mode_in ||
        in_application_programming_in;
      flash_write_lock_out <= live0[`OBCD_B0_WLOCK];
      // factor only matters while the pll runs
      pll_factor_sel_out <= live1[`OBCD_B1_PLL_FACTOR] && !live1[`OBCD_B1_MAIN_BYPASS];
      main_pll_bypass_out <= live1[`OBCD_B1_MAIN_BYPASS];
      timer_pll_bypass_out <= live1[`OBCD_B1_TIMER_BYPASS];
      rc_osc_on_out <= !rc_off;
      low_voltage_detector_en_out <= live1[`OBCD_B1_LVD_HI:`OBCD_B1_LVD_LO] != `OBCD_LVD_OFF;
      low_voltage_detector_level_out <= live1[`OBCD_B1_LVD_HI:`OBCD_B1_LVD_LO];
      watchdog_sw_mode_out <= live1[`OBCD_B1_WATCHDOG_SW_MODE];
      watchdog_hw_enable_out <= !live1[`OBCD_B1_WATCHDOG_SW_MODE];
      watchdog_halt_reset_out <= live1[`OBCD_B1_WATCHDOG_HALT_RESET];
      halt_reset_req_out <= live1[`OBCD_B1_WATCHDOG_HALT_RESET] && watchdog_active_in &&
        halt_entry_in && !load_pending;
    end
  end

endmodule // obcd_core
`default_nettype wire

/* verification/obcd_core_sva.sv */
// checker for the option byte decoder top
// assumes one core clock and the async active-low device reset
`timescale 1ns/1ps
`default_nettype none
module obcd_core_sva (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic prog_mode_in,
  input wire logic user_mode_in,
  input wire logic in_application_programming_in,
  input wire logic watchdog_active_in,
  input wire logic halt_entry_in,
  input wire logic [3:0] addr_in,
  input wire logic rd_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [2:0] osc_range_sel_out,
  input wire logic [1:0] sector0_size_sel_out,
  input wire logic [12:0] sector0_bytes_out,
  input wire logic readout_protect_out,
  input wire logic mem_access_allow_out,
  input wire logic pll_factor_sel_out,
  input wire logic main_pll_bypass_out,
  input wire logic low_voltage_detector_en_out,
  input wire logic [1:0] low_voltage_detector_level_out,
  input wire logic watchdog_sw_mode_out,
  input wire logic watchdog_hw_enable_out,
  input wire logic watchdog_halt_reset_out,
  input wire logic halt_reset_req_out
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [2:0] cnt;
  // edges since reset release, saturating
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt <= 3'h0;
    else if (cnt != 3'h4) cnt <= cnt + 3'h1;
  end
  chk_rd_idle: assert property (!rd_in |=> rd_data_out == 8'h00) else $error("read data without read");
  chk_rd_gated: assert property (!prog_mode_in [*4] ##0 (rd_in && addr_in[3:1] != 3'h1)
    |=> rd_data_out == 8'h00) else $error("byte read outside programming");
  chk_lvd_enable: assert property (low_voltage_detector_en_out == (low_voltage_detector_level_out != 2'h3))
    else $error("detector enable wrong");
  chk_wdg_pair: assert property (watchdog_hw_enable_out != watchdog_sw_mode_out) else $error("watchdog mode");
  chk_pll_factor: assert property (main_pll_bypass_out |-> !pll_factor_sel_out) else $error("pll factor");
  chk_sector_size: assert property (sector0_bytes_out == (13'h0200 << sector0_size_sel_out))
    else $error("sector size wrong");
  chk_readout_lock: assert property ($past(readout_protect_out && !user_mode_in
    && !in_application_programming_in) && readout_protect_out |-> !mem_access_allow_out)
    else $error("locked memory open");
  chk_access_open: assert property ((user_mode_in || in_application_programming_in)
    |=> mem_access_allow_out) else $error("user access blocked");
  chk_halt_reset: assert property (watchdog_halt_reset_out && watchdog_active_in && halt_entry_in
    |=> halt_reset_req_out) else $error("no halt reset");
  chk_halt_quiet: assert property (!halt_entry_in |=> !halt_reset_req_out) else $error("stray halt reset");
  chk_static_cfg: assert property (cnt == 3'h4 |-> $stable({osc_range_sel_out, sector0_bytes_out,
    readout_protect_out, pll_factor_sel_out, watchdog_sw_mode_out})) else $error("config moved");
  cov_halt: cover property (halt_reset_req_out);
  cov_user: cover property (mem_access_allow_out && readout_protect_out);
  cov_prog_rd: cover property (rd_in && prog_mode_in);
endmodule // obcd_core_sva
bind obcd_core obcd_core_sva i_obcd_core_sva (.*);
`default_nettype wire

/* verification/obcd_tool_model.sv */
// programming tool model: mode pin and whole memory erase answer
// assumes the core clock of the bench
`timescale 1ns/1ps
`default_nettype none
module obcd_tool_model #(parameter int DELAY = 4) (
  input wire logic core_clk_in,
  input wire logic tool_on_in,
  input wire logic mass_erase_req_in,
  output logic prog_mode_out,
  output logic mass_erase_done_out
);
  // ****************************************
  // behaviour
  // ****************************************
  int cnt = 0;
  // mode pin high only while the tool is attached
  assign prog_mode_out = tool_on_in;
  // wipe takes DELAY cycles before done
  assign mass_erase_done_out = mass_erase_req_in && cnt == DELAY;
  always @(posedge core_clk_in) begin
    cnt <= mass_erase_req_in ? cnt + 1 : 0;
  end
endmodule // obcd_tool_model
`default_nettype wire

/* verification/obcd_core_tb.sv */
// self-checking bench for the option byte decoder
// assumes the tool model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module obcd_core_tb;
  // ****************************************
  // signals and tasks
  // ****************************************
  logic core_clk_in = 0, rst_n_in = 0, por_n_in = 0, tool_on = 0, wr_in = 0, rd_in = 0;
  logic user_mode_in = 0, in_application_programming_in = 0, watchdog_active_in = 0, halt_entry_in = 0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wr_data_in = 8'h00, rd_data_out, q, b0, b1, prev;
  logic prog_mode_in, mass_erase_done_in, mass_erase_req_out, range_1_2mhz_out, range_2_4mhz_out;
  logic range_4_8mhz_out, range_8_16mhz_out, range_32khz_out, external_clock_input_osc1_out;
  logic external_clock_input_alt_out, osc_range_reserved_out, readout_protect_out, mem_access_allow_out;
  logic flash_write_lock_out, pll_factor_sel_out, main_pll_bypass_out, timer_pll_bypass_out, rc_osc_on_out;
  logic low_voltage_detector_en_out, watchdog_sw_mode_out, watchdog_hw_enable_out, watchdog_halt_reset_out;
  logic halt_reset_req_out;
  logic [2:0] osc_range_sel_out;
  logic [1:0] sector0_size_sel_out, low_voltage_detector_level_out;
  logic [12:0] sector0_bytes_out;
  int fails = 0, total_checks = 0;
  wire [7:0] flags = {external_clock_input_alt_out, osc_range_reserved_out, external_clock_input_osc1_out,
    range_32khz_out, range_8_16mhz_out, range_4_8mhz_out, range_2_4mhz_out, range_1_2mhz_out};
  obcd_core i_obcd_core (.*);
  obcd_tool_model i_obcd_tool_model (.core_clk_in(core_clk_in), .tool_on_in(tool_on),
    .mass_erase_req_in(mass_erase_req_out), .prog_mode_out(prog_mode_in),
    .mass_erase_done_out(mass_erase_done_in));
  initial forever #12.5 core_clk_in = ~core_clk_in;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in); wr_in <= 1'b1; addr_in <= a; wr_data_in <= d;
    @(posedge core_clk_in); wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_in); rd_in <= 1'b1; addr_in <= a;
    @(posedge core_clk_in); rd_in <= 1'b0;
    #1 d = rd_data_out;
  endtask
  task automatic dec(input logic [7:0] c0, input logic [7:0] c1);
    chk(osc_range_sel_out, c0[6:4]);
    chk(flags, c1[4] ? 8'h01 << c0[6:4] : 8'h00);
    chk(sector0_bytes_out, 13'h0200 << c0[3:2]);
    chk(sector0_size_sel_out, c0[3:2]);
    chk({readout_protect_out, mem_access_allow_out, flash_write_lock_out}, {c0[1], !c0[1], c0[0]});
    chk({pll_factor_sel_out, main_pll_bypass_out}, {c1[7] & !c1[6], c1[6]});
    chk({timer_pll_bypass_out, rc_osc_on_out}, {c1[5], !c1[4]});
    chk({low_voltage_detector_en_out, low_voltage_detector_level_out}, {c1[3:2] != 2'h3, c1[3:2]});
    chk({watchdog_sw_mode_out, watchdog_hw_enable_out, watchdog_halt_reset_out}, {c1[1], !c1[1], c1[0]});
    @(posedge core_clk_in); watchdog_active_in <= 1'b1; halt_entry_in <= 1'b1;
    @(posedge core_clk_in); halt_entry_in <= 1'b0;
    #1 chk(halt_reset_req_out, c1[0]);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    #100000 fails++;
    report_and_stop;
  end
  initial begin
    prev = 8'hff;
    repeat (16) @(posedge core_clk_in);
    por_n_in <= 1'b1; rst_n_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    #1 dec(8'hff, 8'hff);
    rd(4'h1, q); chk(q, 8'h00);
    wr(4'h1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_in); {user_mode_in, in_application_programming_in} <= k[1:0];
      repeat (2) @(posedge core_clk_in);
      #1 chk(mem_access_allow_out, k != 0);
    end
    $display("test blank device done");
    @(posedge core_clk_in);
    tool_on <= 1'b1;
    {user_mode_in, in_application_programming_in} <= 2'h0;
    repeat (4) @(posedge core_clk_in);
    rd(4'h1, q); chk(q, 8'hff);
    rd(4'h2, q); chk(q, 8'h01);
    wr(4'h0, 8'h80); rd(4'h0, q); chk(q, 8'h81);
    wr(4'h3, 8'h01); rd(4'h2, q); chk(q, 8'h05);
    chk(mass_erase_req_out, 1'b0);
    wr(4'h3, 8'h02); rd(4'h2, q); chk(q, 8'h01);
    $display("test programming access done");
    for (int i = 0; i < 9; i++) begin
      // top bit written one, range at default under rc
      b0 = {1'b1, (i == 8) ? 3'h7 : i[2:0], i[1:0], i[0], 1'b1};
      b1 = {i[0], i[1], i[2], !i[3], i[1:0], i[1], !i[0]};
      wr(4'h0, b0);
      wr(4'h1, b1);
      #1 chk(osc_range_sel_out, prev[6:4]);
      @(posedge core_clk_in); rst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in); rst_n_in <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      #1 dec(b0, b1);
      @(posedge core_clk_in);
      watchdog_active_in <= 1'b0;
      rd(4'h4, q);
      chk(q, b0);
      rd(4'h5, q);
      chk(q, b1);
      prev = b0;
    end
    $display("test decode table done");
    report_and_stop;
  end
endmodule // obcd_core_tb
`default_nettype wire
